// ---- core/vss_pkg.sv ----
// Shared constants for the vertical sync separator
package vss_pkg;
    localparam int         SAMPLE_W      = 12;
    localparam int         INTEG_W       = 16;
    localparam int         PERIOD_W      = 16;
    // Slice margin above the sync tip, in millivolt codes of the sample
    localparam int         SLICE_MV      = 70;
    localparam logic [11:0] SLICE_CODE   = 12'h0046;
    // Vertical pulse lasts this many oscillator periods
    localparam int         VSYNC_PERIODS = 8;
    localparam logic [3:0] VSYNC_LAST    = 4'h8;
    // Tip tracker relaxes upward one code every this many cycles plus one
    localparam logic [15:0] TIP_RELAX    = 16'h0400;
    localparam logic [11:0] TIP_RESET    = 12'h0fff;
    localparam logic [15:0] INTEG_RESET  = 16'h0000;
    typedef enum logic [1:0]
    {
        VSS_IDLE  = 2'b00,
        VSS_PULSE = 2'b01
    } vss_state_t;
endpackage

// ---- core/vss_osc_if.sv ----
// Link between the vertical latch and its oscillator divider
`timescale 1ns/1ps
interface vss_osc_if;
    logic                          run;
    logic [vss_pkg::PERIOD_W-1:0] period;
    logic                          tick;
    modport ctrl (output run, output period, input tick);
    modport osc  (input run, input period, output tick);
endinterface

// ---- core/vss_osc.sv ----
// Gated oscillator model: one tick per programmed period while running
`timescale 1ns/1ps
module vss_osc
(
    input  wire logic clk,
    input  wire logic rst,
    vss_osc_if.osc    link
);
    logic [vss_pkg::PERIOD_W-1:0] cnt_q;
    logic [vss_pkg::PERIOD_W-1:0] cnt_d;
    logic                          tick_q;
    logic                          wrap;

    // Restarts from phase zero each time the latch sets, like the gated RC
    assign wrap  = (cnt_q + 1'b1 >= link.period);
    assign cnt_d = (!link.run || wrap) ? '0 : cnt_q + 1'b1;
    assign link.tick = tick_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            tick_q <= link.run && wrap;
        end
    end
endmodule // vss_osc

// ---- core/vss_top.sv ----
// Vertical sync separator: slicer, integrator, vertical latch, field flag
`timescale 1ns/1ps
module vss_top
#(
    parameter int SAMPLE_W = vss_pkg::SAMPLE_W,
    parameter int INTEG_W  = vss_pkg::INTEG_W,
    parameter int PERIOD_W = vss_pkg::PERIOD_W
)
(
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic [SAMPLE_W-1:0] video_sample,
    input  wire logic [INTEG_W-1:0]  integ_step,
    input  wire logic [INTEG_W-1:0]  serration_threshold,
    input  wire logic [INTEG_W-1:0]  default_threshold,
    input  wire logic [INTEG_W-1:0]  line_gap_threshold,
    input  wire logic [PERIOD_W-1:0] osc_period,
    output logic                     csync_n,
    output logic                     vsync_n,
    output logic                     field_odd
);
    vss_osc_if osc_link ();

    // Sync tip clamp tracker
    logic [SAMPLE_W-1:0] tip_q;
    logic [SAMPLE_W-1:0] tip_d;
    logic [15:0]         relax_q;
    logic                relax_due;
    logic [SAMPLE_W:0]   slice_level;
    logic                below_slice;

    assign relax_due   = (relax_q == vss_pkg::TIP_RELAX);
    // Snap down instantly, creep up slowly so noise cannot lift the clamp
    assign tip_d       = (video_sample < tip_q) ? video_sample :
                         (relax_due && tip_q != '1) ? tip_q + 1'b1 : tip_q;
    assign slice_level = {1'b0, tip_q} + {1'b0, vss_pkg::SLICE_CODE};
    assign below_slice = ({1'b0, video_sample} < slice_level);

    // Inverted composite sync registered for edge detection, high during sync
    logic sync_q;
    logic sync_fall;
    logic sync_rise;
    assign sync_fall = sync_q && !below_slice;
    assign sync_rise = !sync_q && below_slice;

    // Integrator: ramps while sync is high, dumped between syncs
    logic [INTEG_W-1:0] integ_q;
    logic [INTEG_W-1:0] integ_d;
    logic [INTEG_W:0]   integ_sum;
    logic               above_lower;
    logic               above_upper;

    assign integ_sum   = {1'b0, integ_q} + {1'b0, integ_step};
    // Saturate so a long default wait cannot wrap back under the thresholds
    assign integ_d     = !below_slice ? '0 :
                         integ_sum[INTEG_W] ? '1 :
                         integ_sum[INTEG_W-1:0];
    // Zero step or unreachable threshold leaves the latch untouched
    assign above_lower = (integ_q >= serration_threshold);
    assign above_upper = (integ_q >= default_threshold);

    // Sampling flop result and OR into the latch set
    logic sample_q;
    logic sample_d;
    logic set_req;
    assign sample_d = sync_fall && above_lower;
    assign set_req  = sample_q || (below_slice && above_upper);

    // Vertical latch and its divide-by-eight
    vss_pkg::vss_state_t state_q;
    vss_pkg::vss_state_t state_d;
    logic [3:0]          div_q;
    logic [3:0]          div_d;
    logic                div_done;
    logic                latch_set;

    assign div_done  = osc_link.tick && (div_q + 1'b1 == vss_pkg::VSYNC_LAST);
    assign latch_set = (state_q == vss_pkg::VSS_IDLE) && set_req;

    always_comb
    begin
        state_d = state_q;
        div_d   = div_q;
        case (state_q)
            vss_pkg::VSS_IDLE:
            begin
                div_d = 4'h0;
                // A later serration or trailing edge may retrigger
                if (set_req)
                begin
                    state_d = vss_pkg::VSS_PULSE;
                end
            end
            vss_pkg::VSS_PULSE:
            begin
                if (div_done)
                begin
                    state_d = vss_pkg::VSS_IDLE;
                    div_d   = 4'h0;
                end
                else if (osc_link.tick)
                begin
                    div_d = div_q + 1'b1;
                end
            end
            default:
            begin
                state_d = vss_pkg::VSS_IDLE;
                div_d   = 4'h0;
            end
        endcase
    end

    assign osc_link.run    = (state_q == vss_pkg::VSS_PULSE);
    assign osc_link.period = osc_period;

    vss_osc u_osc
    (
        .clk  (clk),
        .rst  (rst),
        .link (osc_link)
    );

    // Field detector: a toggle clocked by each sync, cleared by a long gap
    logic [INTEG_W-1:0] gap_q;
    logic [INTEG_W-1:0] gap_d;
    logic               toggle_q;
    logic               toggle_d;
    logic               gap_long;
    logic               field_d;

    assign gap_long = (gap_q >= line_gap_threshold);
    assign gap_d    = below_slice ? '0 :
                      (gap_q == '1) ? gap_q : gap_q + 1'b1;
    // Half-line gaps toggle; full lines hold it low, so parity differs
    assign toggle_d = !sync_rise ? toggle_q :
                      gap_long ? 1'b0 : !toggle_q;
    // Parity captured at latch set, held for the whole field
    assign field_d  = latch_set ? toggle_q : field_odd;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tip_q    <= vss_pkg::TIP_RESET;
            relax_q  <= 16'h0000;
            sync_q   <= 1'b0;
            integ_q  <= vss_pkg::INTEG_RESET;
            sample_q <= 1'b0;
            state_q  <= vss_pkg::VSS_IDLE;
            div_q    <= 4'h0;
            gap_q    <= '0;
            toggle_q <= 1'b0;
        end
        else
        begin
            tip_q    <= tip_d;
            relax_q  <= relax_due ? 16'h0000 : relax_q + 16'h0001;
            sync_q   <= below_slice;
            integ_q  <= integ_d;
            sample_q <= sample_d;
            state_q  <= state_d;
            div_q    <= div_d;
            gap_q    <= gap_d;
            toggle_q <= toggle_d;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            csync_n   <= 1'b1;
            vsync_n   <= 1'b1;
            field_odd <= 1'b0;
        end
        else
        begin
            csync_n   <= !below_slice;
            vsync_n   <= !(state_d == vss_pkg::VSS_PULSE);
            field_odd <= field_d;
        end
    end
endmodule // vss_top

// ---- test/vss_props.sv ----
// Assertion checker bound to the vertical sync separator
`timescale 1ns/1ps
module vss_props
#(
    parameter int INTEG_W  = 16,
    parameter int PERIOD_W = 16
)
(
    input wire logic                clk,
    input wire logic                rst,
    input wire logic [INTEG_W-1:0]  integ_step,
    input wire logic [PERIOD_W-1:0] osc_period,
    input wire logic                csync_n,
    input wire logic                vsync_n,
    input wire logic                field_odd
);
    int         low_q;
    int         hi_q;
    int         full;
    logic [2:0] zero_q;
    always_comb full = 8 * int'(osc_period);
    always_ff @(posedge clk)
    begin
        low_q  <= (rst || vsync_n) ? 0 : low_q + 1;
        hi_q   <= (rst || !csync_n) ? 0 : hi_q + 1;
        // Once cleared with zero slope the integrator cannot climb
        zero_q <= (rst || integ_step != '0) ? 3'h0 :
                  (csync_n && zero_q != 3'h7) ? zero_q + 3'h1 : zero_q;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_RST_VS:
        assert property ($fell(rst) |-> vsync_n && csync_n)
        else $error("outputs busy after reset");
    AST_RST_FLD:
        assert property ($fell(rst) |-> !field_odd)
        else $error("field set after reset");
    AST_MIN_LOW:
        assert property ($fell(vsync_n) |-> (!vsync_n)[*7])
        else $error("pulse too short");
    AST_MAX_LOW:
        assert property (low_q <= full + 1)
        else $error("pulse too long");
    AST_HOLD:
        assert property (!vsync_n && low_q < full - 2 |=> !vsync_n)
        else $error("pulse ended early");
    AST_CAUSE:
        assert property ($fell(vsync_n) |-> hi_q < 5)
        else $error("pulse without sync edge");
    AST_NO_RAMP:
        assert property ($fell(vsync_n) |-> zero_q < 3'h4)
        else $error("pulse with zero slope");
    AST_FIELD:
        assert property ($changed(field_odd) |-> $fell(vsync_n))
        else $error("field moved outside latch set");
    C_SER: cover property ($fell(vsync_n) && csync_n);
    C_DEF: cover property ($fell(vsync_n) && !csync_n);
    C_TWO: cover property ($rose(vsync_n) ##[1:40] $fell(vsync_n));
endmodule // vss_props

bind vss_top vss_props #(.INTEG_W(INTEG_W), .PERIOD_W(PERIOD_W)) u_props
(
    .clk(clk), .rst(rst), .integ_step(integ_step),
    .osc_period(osc_period), .csync_n(csync_n),
    .vsync_n(vsync_n), .field_odd(field_odd)
);

// ---- test/vss_src.sv ----
// Video source model: sync tips and changing picture
`timescale 1ns/1ps
module vss_src
(
    input  wire logic   clk,
    input  wire logic   sync_on,
    output logic [11:0] video_sample
);
    logic [11:0] pic_q = 12'h0200;
    // New picture each cycle so a stale slice shows
    always @(negedge clk)
        pic_q <= 12'h0200 + 12'($urandom % 1024);
    assign video_sample = sync_on ? 12'h0100 : pic_q;
endmodule // vss_src

// ---- test/vss_top_tb.sv ----
// Self-checking bench for the vertical sync separator
`timescale 1ns/1ps
module vss_top_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        sync_on = 1'b1;
    logic [11:0] video;
    logic [15:0] step = 16'h0001;
    logic [15:0] thr_lo = 16'h0014;
    logic [15:0] thr_hi = 16'h03e8;
    logic [15:0] period = 16'h0002;
    logic        csync_n;
    logic        vsync_n;
    logic        field_odd;
    int          n_fail;
    int          check_count;
    int          run;
    int          fld_exp;
    int          widths[$];
    always #25 clk = ~clk;
    vss_src SRC (.clk(clk), .sync_on(sync_on), .video_sample(video));
    vss_top DUT (.clk(clk), .rst(rst), .video_sample(video),
        .integ_step(step), .serration_threshold(thr_lo),
        .default_threshold(thr_hi), .line_gap_threshold(16'h001e),
        .osc_period(period), .csync_n(csync_n), .vsync_n(vsync_n),
        .field_odd(field_odd));
    // Counted mid-cycle, well away from the edge that launches vsync_n
    always @(negedge clk)
        if (!rst && vsync_n === 1'b0)
            run++;
        else if (run > 0)
        begin
            widths.push_back(run);
            run = 0;
        end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask
    task seg(input logic v, input int n);
        sync_on = v;
        repeat (n) @(negedge clk);
    endtask
    task lines(input int n);
        repeat (n)
        begin
            seg(1'b1, 2);
            chk(csync_n, 1'b0);
            seg(1'b1, 2);
            seg(1'b0, 2);
            chk(csync_n, 1'b1);
            seg(1'b0, 38);
        end
    endtask
    function automatic int model(int s, int d, int p, int l, int nb,
                                 int lo);
        int e = -1000;
        int n = 0;
        int b;
        int t;
        for (int k = 0; k < nb; k++)
        begin
            b = k * (l + 4);
            // Default start: first sync cycle whose ramp reaches d
            t = (s > 0) ? b + (d + s - 1) / s : b + l;
            while (t < b + l)
            begin
                if (t < e)
                    t = e;
                else
                begin
                    n++;
                    fld_exp = k % 2;
                    e = t + 8 * p + 2;
                end
            end
            // Serration edge reaches the latch a cycle after sync ends
            t = b + l + 1;
            if (s * l >= lo && t >= e)
            begin
                n++;
                fld_exp = k % 2;
                e = t + 8 * p + 2;
            end
        end
        return n;
    endfunction
    task vtest(input int s, input int d, input int p, input int l,
               input int nb);
        int ne;
        step = s[15:0];
        thr_hi = d[15:0];
        period = p[15:0];
        widths.delete();
        lines(3);
        repeat (nb)
        begin
            seg(1'b1, l);
            seg(1'b0, 4);
        end
        lines(2);
        seg(1'b0, 8 * p + 20);
        ne = model(s, d, p, l, nb, thr_lo);
        chk(widths.size(), ne);
        chk(field_odd, fld_exp);
        foreach (widths[i])
            chk(widths[i] inside {[8 * p - 1 : 8 * p + 1]}, 1);
        $display("Test done: step %0d period %0d pulses %0d", s, p, ne);
    endtask
    task finish_test();
        $display("Checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        void'($urandom(32'h0000_bdc2));
        repeat (12) @(negedge clk);
        rst = 1'b0;
        chk(vsync_n, 1'b1);
        chk(field_odd, 1'b0);
        vtest(1 + $urandom % 3, 1000, 20, 40, 3);
        for (int i = 0; i < 3; i++)
            vtest(1 + $urandom % 3, 1000, 2 + $urandom % 3, 40, 3);
        vtest(2, 1000, 2, 40, 2);
        vtest(0, 1000, 4, 40, 3);
        // Shallow ramp never reaches a raised lower threshold
        thr_lo = 16'h003c;
        vtest(1, 1000, 4, 40, 3);
        thr_lo = 16'h0014;
        vtest(1, 60, 20, 100, 1);
        // Short default pulse, then the trailing edge starts another
        vtest(1, 60, 1, 70, 1);
        finish_test();
    end
    initial
    begin
        #2000000;
        n_fail++;
        $display("ERROR %0t: watchdog expired", $time);
        finish_test();
    end
endmodule // vss_top_tb
